// *** tie_pkg.sv ***
// Constants shared by the tail-group instruction executor
package tie_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 8;
   localparam int PC_W = 12;
   localparam int ROM_W = 15;
   localparam int HIGH_W = ROM_W - DATA_W;
   localparam int OP_W = 4;
   localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
   localparam logic [HIGH_W-1:0] HIGH_RESET = 7'h00;
   localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
   localparam logic [PC_W-DATA_W-1:0] LAST_PAGE = 4'hf;
   localparam int NIB_LO = 0;
   localparam int NIB_HI = 4;
   localparam int NIB_W = 4;
   localparam int SKIP_CYCLES = 2;

   // Operation codes presented by the decoder upstream
   typedef enum logic [OP_W-1:0] {
      TIE_OP_NONE = 4'h0,
      TIE_OP_SWAP_ACC = 4'h1,
      TIE_OP_SKIP_BYTE_ZERO = 4'h2,
      TIE_OP_MOVE_SKIP_ZERO = 4'h3,
      TIE_OP_SKIP_BIT_ZERO = 4'h4,
      TIE_OP_TABLE_CUR = 4'h5,
      TIE_OP_TABLE_LAST = 4'h6,
      TIE_OP_XOR_ACC = 4'h7,
      TIE_OP_XOR_MEM = 4'h8,
      TIE_OP_XOR_IMM = 4'h9
   } tie_op_e;

   // Execution states, Gray coded along the normal path
   typedef enum logic [1:0] {
      TIE_ST_EXEC = 2'b00,
      TIE_ST_DUMMY = 2'b01,
      TIE_ST_TABLE = 2'b10
   } tie_state_e;
endpackage : tie_pkg

// *** tie_alu.sv ***
// Combinational result and test unit for the tail instruction group
`timescale 1ns/1ps
`default_nettype none
module tie_alu (
   // Operands
   input wire logic [tie_pkg::DATA_W-1:0] acc,
   input wire logic [tie_pkg::DATA_W-1:0] mem,
   input wire logic [tie_pkg::DATA_W-1:0] imm,
   input wire logic [2:0] bit_sel,
   // Results
   output logic [tie_pkg::DATA_W-1:0] swapped,
   output logic [tie_pkg::DATA_W-1:0] xor_mem,
   output logic [tie_pkg::DATA_W-1:0] xor_imm,
   output logic byte_zero,
   output logic bit_zero
);
   // Upper nibble goes low, lower nibble goes high
   assign swapped = {mem[tie_pkg::NIB_LO +: tie_pkg::NIB_W], mem[tie_pkg::NIB_HI +: tie_pkg::NIB_W]};
   assign xor_mem = acc ^ mem;
   assign xor_imm = acc ^ imm;
   assign byte_zero = (mem == tie_pkg::ZERO_BYTE);
   assign bit_zero = ~mem[bit_sel];
endmodule : tie_alu
`default_nettype wire

// *** tie_exec.sv ***
// Executor for swap, zero-skip, table-read and exclusive-OR instructions
// Overview of operation
// - Swap puts high nibble low, low nibble high
// - Swap leaves the data byte untouched
// - Zero byte skips with dummy cycle, two cycles
// - Move to accumulator, skip when zero
// - Clear selected bit skips with dummy cycle
// - Skip discards prefetched word, inserts dummy cycle
// - Current-page table read fills byte and latch
// - Last-page table read fills byte and latch
// - Memory xor into accumulator sets zero flag
// - Xor into memory keeps accumulator, sets zero
// - Immediate xor into accumulator sets zero flag
`timescale 1ns/1ps
`default_nettype none
module tie_exec (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Instruction issue from the decoder
   input wire logic issue_valid,
   input wire logic [tie_pkg::OP_W-1:0] issue_op,
   input wire logic [tie_pkg::ADDR_W-1:0] issue_addr,
   input wire logic [2:0] issue_bit,
   input wire logic [tie_pkg::DATA_W-1:0] issue_imm,
   output logic issue_ready,
   // Data memory read port (combinational) and write port
   output logic [tie_pkg::ADDR_W-1:0] mem_addr,
   input wire logic [tie_pkg::DATA_W-1:0] mem_rdata,
   output logic mem_we,
   output logic [tie_pkg::DATA_W-1:0] mem_wdata,
   // Program memory table port, data valid the cycle after the request
   input wire logic [tie_pkg::PC_W-1:0] pc,
   output logic rom_re,
   output logic [tie_pkg::PC_W-1:0] rom_addr,
   input wire logic [tie_pkg::ROM_W-1:0] rom_rdata,
   // Table pointer from the core
   input wire logic [tie_pkg::DATA_W-1:0] table_pointer_reg,
   // Fetch control
   output logic discard_fetch,
   // Core state
   output logic [tie_pkg::DATA_W-1:0] acc,
   output logic [tie_pkg::HIGH_W-1:0] table_high_latch,
   output logic zero_flag,
   output logic zero_flag_we
);
   tie_pkg::tie_state_e state_reg, state_next;
   logic [tie_pkg::DATA_W-1:0] acc_reg, acc_next;
   logic [tie_pkg::HIGH_W-1:0] high_reg, high_next;
   logic [tie_pkg::ADDR_W-1:0] dest_reg;
   logic [tie_pkg::DATA_W-1:0] swapped, xor_mem, xor_imm;
   logic byte_zero, bit_zero;

   wire logic idle = (state_reg == tie_pkg::TIE_ST_EXEC);
   wire logic go = idle && issue_valid;
   wire tie_pkg::tie_op_e op = tie_pkg::tie_op_e'(issue_op);
   wire logic is_table = go && (op == tie_pkg::TIE_OP_TABLE_CUR || op == tie_pkg::TIE_OP_TABLE_LAST);
   wire logic take_skip = go && ((op == tie_pkg::TIE_OP_SKIP_BYTE_ZERO && byte_zero)
      || (op == tie_pkg::TIE_OP_MOVE_SKIP_ZERO && byte_zero)
      || (op == tie_pkg::TIE_OP_SKIP_BIT_ZERO && bit_zero));
   wire logic [tie_pkg::PC_W-tie_pkg::DATA_W-1:0] page_sel =
      (op == tie_pkg::TIE_OP_TABLE_LAST) ? tie_pkg::LAST_PAGE : pc[tie_pkg::PC_W-1:tie_pkg::DATA_W];
   wire logic table_done = (state_reg == tie_pkg::TIE_ST_TABLE);

   tie_alu u_alu (
      .acc(acc_reg),
      .mem(mem_rdata),
      .imm(issue_imm),
      .bit_sel(issue_bit),
      .swapped(swapped),
      .xor_mem(xor_mem),
      .xor_imm(xor_imm),
      .byte_zero(byte_zero),
      .bit_zero(bit_zero)
   );

   assign issue_ready = idle;
   assign mem_addr = table_done ? dest_reg : issue_addr;
   assign rom_re = is_table;
   assign rom_addr = {page_sel, table_pointer_reg};
   assign discard_fetch = take_skip;

   // Memory writes: only xor-into-memory and the second table cycle; swap never writes
   assign mem_we = table_done || (go && op == tie_pkg::TIE_OP_XOR_MEM);
   assign mem_wdata = table_done ? rom_rdata[tie_pkg::DATA_W-1:0] : xor_mem;

   // Only the three xor forms touch a flag, and only zero
   assign zero_flag_we = go && (op == tie_pkg::TIE_OP_XOR_ACC || op == tie_pkg::TIE_OP_XOR_MEM
      || op == tie_pkg::TIE_OP_XOR_IMM);
   assign zero_flag = (op == tie_pkg::TIE_OP_XOR_IMM) ? (xor_imm == tie_pkg::ZERO_BYTE)
      : (xor_mem == tie_pkg::ZERO_BYTE);

   always_comb begin
      acc_next = acc_reg;
      if (go) begin
         unique case (op)
            tie_pkg::TIE_OP_SWAP_ACC: acc_next = swapped;
            tie_pkg::TIE_OP_MOVE_SKIP_ZERO: acc_next = mem_rdata;
            tie_pkg::TIE_OP_XOR_ACC: acc_next = xor_mem;
            tie_pkg::TIE_OP_XOR_IMM: acc_next = xor_imm;
            default: acc_next = acc_reg;
         endcase
      end
   end

   assign high_next = table_done ? rom_rdata[tie_pkg::ROM_W-1:tie_pkg::DATA_W] : high_reg;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         tie_pkg::TIE_ST_EXEC: begin
            if (take_skip) begin
               state_next = tie_pkg::TIE_ST_DUMMY;
            end else if (is_table) begin
               state_next = tie_pkg::TIE_ST_TABLE;
            end
         end
         tie_pkg::TIE_ST_DUMMY: state_next = tie_pkg::TIE_ST_EXEC;
         tie_pkg::TIE_ST_TABLE: state_next = tie_pkg::TIE_ST_EXEC;
         default: state_next = tie_pkg::TIE_ST_EXEC;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= tie_pkg::TIE_ST_EXEC;
         acc_reg <= tie_pkg::ACC_RESET;
         high_reg <= tie_pkg::HIGH_RESET;
         dest_reg <= '0;
      end else begin
         state_reg <= state_next;
         acc_reg <= acc_next;
         high_reg <= high_next;
         if (is_table) begin
            dest_reg <= issue_addr;
         end
      end
   end

   assign acc = acc_reg;
   assign table_high_latch = high_reg;

   // Checks
   sequence s_skip_issue;
      go && take_skip;
   endsequence
   sequence s_dummy_then_ready;
      !issue_ready ##1 issue_ready;
   endsequence

   a_skip_two_cycles: assert property (@(posedge clk) disable iff (rst)
      s_skip_issue |=> s_dummy_then_ready) else $error("skip did not take two cycles");
   a_no_skip_one: assert property (@(posedge clk) disable iff (rst)
      (go && !take_skip && !is_table) |=> issue_ready) else $error("non-skip stalled");
   a_swap_result: assert property (@(posedge clk) disable iff (rst)
      (go && op == tie_pkg::TIE_OP_SWAP_ACC) |=> acc == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])})
      else $error("swap result wrong");
   a_swap_no_write: assert property (@(posedge clk) disable iff (rst)
      (go && op == tie_pkg::TIE_OP_SWAP_ACC) |-> !mem_we) else $error("swap wrote memory");
   a_move_skip: assert property (@(posedge clk) disable iff (rst)
      (go && op == tie_pkg::TIE_OP_MOVE_SKIP_ZERO) |-> (discard_fetch == (mem_rdata == 8'h00))
      ##1 acc == $past(mem_rdata)) else $error("move and skip wrong");
   a_bit_skip: assert property (@(posedge clk) disable iff (rst)
      (go && op == tie_pkg::TIE_OP_SKIP_BIT_ZERO) |-> discard_fetch == !mem_rdata[issue_bit])
      else $error("bit skip wrong");
   a_table_last: assert property (@(posedge clk) disable iff (rst)
      (go && op == tie_pkg::TIE_OP_TABLE_LAST) |-> rom_re && rom_addr[11:8] == 4'hf
      ##1 mem_we && mem_addr == $past(issue_addr)) else $error("last-page table read wrong");
   a_table_high: assert property (@(posedge clk) disable iff (rst)
      table_done |=> table_high_latch == $past(rom_rdata[14:8])) else $error("table high latch wrong");
   a_xor_mem_acc: assert property (@(posedge clk) disable iff (rst)
      (go && op == tie_pkg::TIE_OP_XOR_MEM) |-> mem_we && mem_wdata == (acc ^ mem_rdata) ##1 $stable(acc))
      else $error("xor into memory wrong");
   a_flags_kept: assert property (@(posedge clk) disable iff (rst)
      (go && op inside {tie_pkg::TIE_OP_SWAP_ACC, tie_pkg::TIE_OP_SKIP_BYTE_ZERO, tie_pkg::TIE_OP_TABLE_CUR,
      tie_pkg::TIE_OP_MOVE_SKIP_ZERO, tie_pkg::TIE_OP_SKIP_BIT_ZERO, tie_pkg::TIE_OP_TABLE_LAST})
      |-> !zero_flag_we) else $error("flag touched");
   a_xor_zero: assert property (@(posedge clk) disable iff (rst)
      (go && op == tie_pkg::TIE_OP_XOR_IMM) |-> zero_flag_we && zero_flag == ((acc ^ issue_imm) == 8'h00))
      else $error("xor zero flag wrong");

   // Table reads: pointer request in the issue cycle, write-back in the next
   sequence s_table_issue;
      go && is_table;
   endsequence
   sequence s_table_write;
      table_done && mem_we && mem_addr == $past(issue_addr) && mem_wdata == rom_rdata[7:0];
   endsequence

   a_table_cur: assert property (@(posedge clk) disable iff (rst)
      (go && op == tie_pkg::TIE_OP_TABLE_CUR) |-> rom_re && rom_addr == {pc[11:8], table_pointer_reg}
      ##1 s_table_write) else $error("current-page table read wrong");
   a_table_last_data: assert property (@(posedge clk) disable iff (rst)
      (go && op == tie_pkg::TIE_OP_TABLE_LAST) |=> s_table_write)
      else $error("last-page table write wrong");
   a_table_busy: assert property (@(posedge clk) disable iff (rst)
      s_table_issue |=> s_dummy_then_ready) else $error("table read not two cycles");
   a_table_keep_acc: assert property (@(posedge clk) disable iff (rst)
      s_table_issue |=> $stable(acc) ##1 $stable(acc)) else $error("table read changed accumulator");

   // Test skips: nothing written back, and the dummy cycle executes nothing
   a_skip_byte: assert property (@(posedge clk) disable iff (rst)
      (go && op == tie_pkg::TIE_OP_SKIP_BYTE_ZERO) |-> discard_fetch == (mem_rdata == 8'h00))
      else $error("byte skip wrong");
   a_skip_keep_acc: assert property (@(posedge clk) disable iff (rst)
      (go && op inside {tie_pkg::TIE_OP_SKIP_BYTE_ZERO, tie_pkg::TIE_OP_SKIP_BIT_ZERO}) |-> !mem_we
      ##1 $stable(acc)) else $error("test skip changed state");
   a_skip_once: assert property (@(posedge clk) disable iff (rst)
      discard_fetch |=> !discard_fetch) else $error("skip pulse longer than one cycle");
   a_dummy_quiet: assert property (@(posedge clk) disable iff (rst)
      (state_reg == tie_pkg::TIE_ST_DUMMY) |-> !issue_ready && !mem_we && !rom_re && !discard_fetch
      && !zero_flag_we) else $error("dummy cycle not empty");

   // Exclusive-OR results and zero flag
   a_xor_acc: assert property (@(posedge clk) disable iff (rst)
      (go && op == tie_pkg::TIE_OP_XOR_ACC) |-> zero_flag_we && !mem_we
      && zero_flag == ((acc ^ mem_rdata) == 8'h00)
      ##1 acc == ($past(acc) ^ $past(mem_rdata))) else $error("xor into accumulator wrong");
   a_xor_mem_zero: assert property (@(posedge clk) disable iff (rst)
      (go && op == tie_pkg::TIE_OP_XOR_MEM) |-> zero_flag_we && zero_flag == ((acc ^ mem_rdata) == 8'h00))
      else $error("xor into memory zero flag wrong");
   a_xor_imm_acc: assert property (@(posedge clk) disable iff (rst)
      (go && op == tie_pkg::TIE_OP_XOR_IMM) |=> acc == ($past(acc) ^ $past(issue_imm)))
      else $error("immediate xor result wrong");
endmodule : tie_exec
`default_nettype wire

// *** tie_tb.sv ***
// Self-checking bench for the tail-group instruction executor
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic issue_valid = 1'b0;
   logic [3:0] issue_op = 4'h0;
   logic [7:0] issue_addr = 8'h00;
   logic [2:0] issue_bit = 3'h0;
   logic [7:0] issue_imm = 8'h00;
   logic [11:0] pc = 12'h000;
   logic [7:0] tp = 8'h00;
   logic [14:0] rom_q = 15'h0000;
   logic issue_ready, mem_we, rom_re, discard_fetch, zero_flag, zero_flag_we;
   logic [7:0] mem_addr, mem_wdata, acc;
   logic [11:0] rom_addr;
   logic [6:0] table_high_latch;
   logic [7:0] mem [256];
   logic c_disc, c_we, c_zwe, c_zf, c_rre, c_rdy;
   logic [7:0] c_wd;
   logic [11:0] c_ra;
   int err_total = 0;
   int checks_done = 0;

   always #10 clk = ~clk;

   // Program words differ by page and pointer so a wrong page shows up
   function automatic logic [14:0] rom_word(input logic [11:0] a);
      return {{a[11:8], a[2:0]} ^ 7'h2b, a[7:0] ^ 8'h96};
   endfunction : rom_word

   // Data memory and program memory seen by the executor
   always @(posedge clk) begin
      if (mem_we) mem[mem_addr] <= mem_wdata;
      if (rom_re) rom_q <= rom_word(rom_addr);
   end

   tie_exec dut_u (.clk(clk), .rst(rst), .issue_valid(issue_valid), .issue_op(issue_op),
      .issue_addr(issue_addr), .issue_bit(issue_bit), .issue_imm(issue_imm), .issue_ready(issue_ready),
      .mem_addr(mem_addr), .mem_rdata(mem[mem_addr]), .mem_we(mem_we), .mem_wdata(mem_wdata), .pc(pc),
      .rom_re(rom_re), .rom_addr(rom_addr), .rom_rdata(rom_q), .table_pointer_reg(tp),
      .discard_fetch(discard_fetch), .acc(acc), .table_high_latch(table_high_latch),
      .zero_flag(zero_flag), .zero_flag_we(zero_flag_we));

   task chk(input string n, input logic [14:0] e, input logic [14:0] g);
      checks_done++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // Issue one instruction, capture its issue-cycle strobes and the ready that follows
   task op(input logic [3:0] o, input logic [7:0] a, input logic [2:0] b, input logic [7:0] i);
      @(posedge clk);
      issue_valid <= 1'b1;
      issue_op <= o;
      issue_addr <= a;
      issue_bit <= b;
      issue_imm <= i;
      #1;
      {c_disc, c_we, c_zwe, c_zf, c_rre, c_wd, c_ra} = {discard_fetch, mem_we, zero_flag_we, zero_flag,
         rom_re, mem_wdata, rom_addr};
      @(posedge clk);
      issue_valid <= 1'b0;
      #1;
      c_rdy = issue_ready;
   endtask : op

   task t_skip(input logic [3:0] o, input logic [7:0] v, input logic [2:0] b, input logic sk);
      mem[8'h20] = v;
      op(o, 8'h20, b, 8'h00);
      chk("discard_fetch", {14'h0, sk}, c_disc);
      chk("issue_ready", {14'h0, !sk}, c_rdy);
      chk("zero_flag_we", 15'h0, c_zwe);
      if (o == 4'h3) chk("acc", v, acc);
   endtask : t_skip

   task t_table(input logic [3:0] o, input logic [3:0] pg);
      logic [14:0] w;
      w = rom_word({pg, tp});
      op(o, 8'h30, 3'h0, 8'h00);
      chk("rom_re", 15'h1, c_rre);
      chk("rom_addr", {pg, tp}, c_ra);
      chk("issue_ready", 15'h0, c_rdy);
      chk("zero_flag_we", 15'h0, c_zwe);
      @(posedge clk);
      #1;
      chk("table byte", w[7:0], mem[8'h30]);
      chk("table_high_latch", w[14:8], table_high_latch);
      $display("table read op %0d done", o);
   endtask : t_table

   task finish_test;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : finish_test

   initial begin
      #200000;
      err_total++;
      finish_test();
   end

   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      #1;
      chk("acc after reset", 15'h0, acc);
      mem[8'h11] = 8'h1e;
      op(4'h1, 8'h11, 3'h0, 8'h00);
      chk("swap acc", 15'he1, acc);
      chk("swap byte", 15'h1e, mem[8'h11]);
      chk("swap mem_we", 15'h0, c_we);
      chk("swap zero_flag_we", 15'h0, c_zwe);
      $display("swap done");
      t_skip(4'h2, 8'h00, 3'h0, 1'b1);
      t_skip(4'h2, 8'h80, 3'h0, 1'b0);
      t_skip(4'h3, 8'h00, 3'h0, 1'b1);
      t_skip(4'h3, 8'h5a, 3'h0, 1'b0);
      for (int b = 0; b < 8; b++) t_skip(4'h4, 8'ha5, 3'(b), ((8'ha5 >> b) & 8'h01) == 8'h00);
      $display("skips done");
      pc = 12'h3c5;
      tp = 8'h47;
      t_table(4'h5, 4'h3);
      t_table(4'h6, 4'hf);
      mem[8'h40] = 8'h35;
      mem[8'h6c] = 8'h00;
      op(4'h3, 8'h6c, 3'h0, 8'h00);
      chk("move zero acc", 15'h0, acc);
      chk("move zero skip", 15'h1, c_disc);
      mem[8'h6c] = 8'h6c;
      op(4'h3, 8'h6c, 3'h0, 8'h00);
      chk("move acc", 15'h6c, acc);
      op(4'h7, 8'h40, 3'h0, 8'h00);
      chk("xor acc", 15'h59, acc);
      chk("xor acc flag", 15'h4, {c_zwe, c_zf, c_we});
      op(4'h8, 8'h40, 3'h0, 8'h00);
      chk("xor mem data", 15'h16c, {c_we, c_wd});
      chk("xor mem flag", 15'h2, {c_zwe, c_zf});
      chk("xor mem acc", 15'h59, acc);
      chk("xor mem byte", 15'h6c, mem[8'h40]);
      op(4'h9, 8'h40, 3'h0, 8'h59);
      chk("xor imm acc", 15'h0, acc);
      chk("xor imm flag", 15'h3, {c_zwe, c_zf});
      mem[8'h50] = 8'h00;
      op(4'h7, 8'h50, 3'h0, 8'h00);
      chk("xor acc zero flag", 15'h6, {c_zwe, c_zf, c_we});
      op(4'h8, 8'h50, 3'h0, 8'h00);
      chk("xor mem zero", 15'h700, {c_zwe, c_zf, c_we, c_wd});
      op(4'h0, 8'h40, 3'h0, 8'hff);
      chk("no-op strobes", 15'h1, {c_disc, c_we, c_zwe, c_rre, c_rdy});
      chk("no-op acc", 15'h0, acc);
      $display("xor done");
      finish_test();
   end
endmodule : testbench
`default_nettype wire
